// file: svr_pkg.sv
// Package with the register map, field layout and carrier types of the sense value readback block
package svr_pkg;

  localparam int unsigned SVR_NUM_CH        = 6;
  localparam int unsigned SVR_CODE_W        = 12;
  localparam int unsigned SVR_REG_W         = 16;
  localparam int unsigned SVR_CODE_LSB      = 4;
  localparam int unsigned SVR_CODE_MSB      = 15;

  // Register indices; byte address is four times the index
  localparam logic [15:0] SVR_IDX_SEC_CUR_A = 16'hFED3;
  localparam logic [15:0] SVR_IDX_SEC_CUR_B = 16'hFED4;
  localparam logic [15:0] SVR_IDX_OUT_VLT_A = 16'hFED5;
  localparam logic [15:0] SVR_IDX_OUT_VLT_B = 16'hFED6;
  localparam logic [15:0] SVR_IDX_TEMP_ONE  = 16'hFED7;
  localparam logic [15:0] SVR_IDX_TEMP_TWO  = 16'hFED8;
  localparam logic [15:0] SVR_IDX_FIRST     = SVR_IDX_SEC_CUR_A;

  // Reset value of every stored code and of the read data word
  localparam logic [11:0] SVR_CODE_RST      = 12'h000;
  localparam logic [31:0] SVR_RDATA_RST     = 32'h0000_0000;

  // Scaling of one LSB, in nanovolts, spans in microvolts, and the nominal output voltage code
  localparam int unsigned SVR_SEC_CUR_NV_PER_LSB = 29300;
  localparam int unsigned SVR_SEC_CUR_SPAN_UV    = 120000;
  localparam int unsigned SVR_VLT_NV_PER_LSB     = 390600;
  localparam int unsigned SVR_VLT_SPAN_UV        = 1600000;
  localparam logic [11:0] SVR_VLT_NOMINAL_CODE   = 12'hA00;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } svr_apb_req_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] code;
  } svr_sample_t;

endpackage : svr_pkg

// file: svr_readback.sv
// APB slave holding the six read-only sense value registers
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module svr_readback
  import svr_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire svr_apb_req_t i_apb,
  input  wire svr_sample_t  i_sample [SVR_NUM_CH],
  output logic              o_pready,
  output logic [31:0]       o_prdata,
  output logic              o_pslverr
);

  // Channel order of i_sample and of the register map:
  // 0 secondary current A, 1 secondary current B,
  // 2 output voltage A, 3 output voltage B,
  // 4 temperature one, 5 temperature two

  // Handshake phase; one-hot so a corrupted code drops back to idle
  typedef enum logic [1:0]
  {
    SVR_PH_IDLE   = 2'b01,
    SVR_PH_ACCESS = 2'b10
  } svr_phase_t;

  svr_phase_t            phase_r;
  svr_phase_t            phase_nxt;
  logic [11:0]           code_r [SVR_NUM_CH];
  logic [11:0]           code_nxt [SVR_NUM_CH];
  logic [31:0]           word [SVR_NUM_CH];
  logic [SVR_NUM_CH-1:0] hit;
  logic [15:0]           idx;
  logic                  upper_clear;
  logic                  aligned;
  logic                  mapped;
  logic                  is_read;
  logic                  setup;
  logic                  pready_nxt;
  logic                  pslverr_nxt;
  logic [31:0]           rdata_nxt;
  logic [31:0]           prdata_nxt;

  // Write data has no destination: every register here is read-only
  genvar g;

  // Converters share this clock, so samples are taken without a synchroniser
  generate
    for (g = 0; g < SVR_NUM_CH; g++)
    begin : g_load
      always_comb
      begin
        code_nxt[g] = code_r[g];
        if (i_sample[g].valid)
        begin
          code_nxt[g] = i_sample[g].code;
        end
      end

      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          code_r[g] <= SVR_CODE_RST;
        end
        else
        begin
          code_r[g] <= code_nxt[g];
        end
      end
    end
  endgenerate

  // Scaling is analog; the code is shown exactly as delivered
  generate
    for (g = 0; g < SVR_NUM_CH; g++)
    begin : g_word
      always_comb
      begin
        word[g]                            = SVR_RDATA_RST;
        word[g][SVR_CODE_MSB:SVR_CODE_LSB] = code_r[g];
      end
    end
  endgenerate

  // Byte address is four times the register index
  always_comb
  begin
    idx         = i_apb.paddr[17:2];
    upper_clear = (i_apb.paddr[31:18] == 14'h0000);
    aligned     = (i_apb.paddr[1:0] == 2'h0);
  end

  generate
    for (g = 0; g < SVR_NUM_CH; g++)
    begin : g_hit
      assign hit[g] = (idx == SVR_IDX_FIRST + 16'(g));
    end
  endgenerate

  always_comb
  begin
    mapped  = upper_clear && aligned && (|hit);
    is_read = !i_apb.pwrite;
  end

  // Setup taken only when idle, so a setup held one cycle too long is not answered twice
  assign setup = i_apb.psel && !i_apb.penable && (phase_r == SVR_PH_IDLE);

  always_comb
  begin
    phase_nxt = phase_r;
    case (phase_r)
      SVR_PH_IDLE:
      begin
        if (setup)
        begin
          phase_nxt = SVR_PH_ACCESS;
        end
      end
      SVR_PH_ACCESS:
      begin
        // Always answered in the first access cycle
        phase_nxt = SVR_PH_IDLE;
      end
      default:
      begin
        phase_nxt = SVR_PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      phase_r <= SVR_PH_IDLE;
    end
    else
    begin
      phase_r <= phase_nxt;
    end
  end

  // Read word; writes and unmapped reads give zero
  // A sample landing on the setup edge is seen by the next read only
  always_comb
  begin
    rdata_nxt = SVR_RDATA_RST;
    for (int c = 0; c < SVR_NUM_CH; c++)
    begin
      if (hit[c] && mapped && is_read)
      begin
        rdata_nxt = rdata_nxt | word[c];
      end
    end
  end

  // Writes to mapped registers are dropped without error
  always_comb
  begin
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = SVR_RDATA_RST;
    if (setup)
    begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !mapped;
      prdata_nxt  = rdata_nxt;
    end
  end

  // Answer in the first access cycle: no wait states
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pready <= 1'b0;
    end
    else
    begin
      o_pready <= pready_nxt;
    end
  end

  // Data stands only while pready is high, zero otherwise
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_prdata <= SVR_RDATA_RST;
    end
    else
    begin
      o_prdata <= prdata_nxt;
    end
  end

  // Error only for an address outside the map or not word aligned
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pslverr <= pslverr_nxt;
    end
  end

endmodule : svr_readback

// file: svr_readback_properties.sv
// Readback checker
`timescale 1ns/1ps
module svr_readback_properties import svr_pkg::*; (
  input wire logic         i_clk,
  input wire logic         i_arst_n,
  input wire svr_apb_req_t i_apb,
  input wire logic         o_pready,
  input wire logic [31:0]  o_prdata,
  input wire logic         o_pslverr
);
  localparam logic [31:0] BYTE_FIRST = {14'h0000, SVR_IDX_SEC_CUR_A, 2'h0};
  localparam logic [31:0] BYTE_LAST  = {14'h0000, SVR_IDX_TEMP_TWO, 2'h0};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_one_ready: assert property (i_apb.psel && !i_apb.penable |=> o_pready ##1 !o_pready) else $error("rdy");
  a_reserved_zero: assert property ((o_prdata & 32'hFFFF_000F) == 0) else $error("rsv");
  a_idle_quiet: assert property (!o_pready |-> (o_prdata == 32'h0) && !o_pslverr) else $error("idle");
  a_write_no_data: assert property (o_pready && i_apb.pwrite |-> o_prdata == 32'h0) else $error("wdata");
  a_mapped_no_err: assert property (
    o_pready && (i_apb.paddr >= BYTE_FIRST) && (i_apb.paddr <= BYTE_LAST) && (i_apb.paddr[1:0] == 2'h0)
    |-> !o_pslverr) else $error("maperr");
  a_odd_addr_err: assert property (o_pready && (i_apb.paddr[1:0] != 2'h0) |-> o_pslverr) else $error("odd");
endmodule : svr_readback_properties
bind svr_readback svr_readback_properties u_props (.*);

// file: sense_value_readback_tb.sv
// Readback bench
`timescale 1ns/1ps
module sense_value_readback_tb import svr_pkg::*;;
  logic         i_clk = 1'b0;
  logic         i_arst_n = 1'b0;
  logic         o_pready;
  logic         o_pslverr;
  logic [31:0]  o_prdata;
  logic [31:0]  b = SVR_IDX_FIRST * 4;
  svr_apb_req_t i_apb = '0;
  svr_sample_t  i_sample [SVR_NUM_CH] = '{default: '0};
  int           fail_count;
  int           n_checks;

  svr_readback u_dut
  (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_apb     (i_apb),
    .i_sample  (i_sample),
    .o_pready  (o_pready),
    .o_prdata  (o_prdata),
    .o_pslverr (o_pslverr)
  );

  task automatic final_report;
    $display("checks %0d fails %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  function automatic logic [32:0] exp_word(input logic [11:0] code);
    return {1'b0, 16'h0000, code, 4'h0};
  endfunction : exp_word

  task automatic check_resp(input logic [32:0] got, input logic [32:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_resp

  // One transfer; the answer is taken at the edge where pready is sampled high
  task automatic xfer(input logic w, input logic [31:0] a, output logic [32:0] resp);
    int n;
    @(posedge i_clk);
    i_apb <= '{1'b1, 1'b0, w, a, 32'hFFFF_FFFF};
    @(posedge i_clk);
    i_apb.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_pready !== 1'b1 && n < 16);
    if (o_pready !== 1'b1)
    begin
      fail_count++;
      $display("wrong value at %0t: no pready", $time);
      final_report();
    end
    resp = {o_pslverr, o_prdata};
    i_apb <= '0;
  endtask : xfer

  task automatic load(input int ch, input logic [11:0] code);
    @(posedge i_clk);
    i_sample[ch] <= '{1'b1, code};
    @(posedge i_clk);
    i_sample[ch].valid <= 1'b0;
  endtask : load

  task automatic t_reset_zero;
    logic [32:0] r;
    for (int i = 0; i < SVR_NUM_CH; i++)
    begin
      xfer(1'b0, b + 32'(4 * i), r);
      check_resp(r, exp_word(12'h000), "code after reset");
    end
    $display("t_reset_zero done");
  endtask : t_reset_zero

  task automatic t_regs;
    logic [32:0] r;
    for (int i = 0; i < SVR_NUM_CH; i++)
      load(i, 12'hA00 + 12'(i));
    for (int i = 0; i < SVR_NUM_CH; i++)
    begin
      xfer(1'b0, b + 32'(4 * i), r);
      check_resp(r, exp_word(12'hA00 + 12'(i)), "loaded code");
    end
    for (int i = 0; i < SVR_NUM_CH; i++)
    begin
      xfer(1'b1, b + 32'(4 * i), r);
      check_resp(r, 33'h0_0000_0000, "write answer");
    end
    for (int i = 0; i < SVR_NUM_CH; i++)
    begin
      xfer(1'b0, b + 32'(4 * i), r);
      check_resp(r, exp_word(12'hA00 + 12'(i)), "code after write");
    end
    load(0, 12'hFFF);
    xfer(1'b0, b, r);
    check_resp(r, exp_word(12'hFFF), "full scale code");
    $display("t_regs done");
  endtask : t_regs

  task automatic t_unmapped;
    logic [32:0] r;
    xfer(1'b1, b + 32'd24, r);
    check_resp(r, 33'h1_0000_0000, "past last register");
    xfer(1'b0, b - 32'd4, r);
    check_resp(r, 33'h1_0000_0000, "before first register");
    xfer(1'b0, b + 32'd2, r);
    check_resp(r, 33'h1_0000_0000, "misaligned read");
    $display("t_unmapped done");
  endtask : t_unmapped

  task automatic t_midrun_reset;
    logic [32:0] r;
    load(3, 12'h5A5);
    xfer(1'b0, b + 32'd12, r);
    check_resp(r, exp_word(12'h5A5), "code before reset");
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    xfer(1'b0, b + 32'd12, r);
    check_resp(r, exp_word(12'h000), "code after mid-run reset");
    $display("t_midrun_reset done");
  endtask : t_midrun_reset

  initial forever #5 i_clk = ~i_clk;

  initial
  begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_reset_zero();
    t_regs();
    t_unmapped();
    t_midrun_reset();
    final_report();
  end
endmodule : sense_value_readback_tb
